// >>> rtl/trd_pkg.sv
// constants, types and register map of the task register dispatch checker
package trd_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0]  OFS_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_SEL    = 8'h04;
    localparam logic [7:0]  OFS_BASE   = 8'h08;
    localparam logic [7:0]  OFS_LIMIT  = 8'h0C;
    localparam logic [7:0]  OFS_ATTR   = 8'h10;
    localparam logic [7:0]  OFS_GATE   = 8'h14;
    localparam logic [7:0]  OFS_STATUS = 8'h18;
    localparam logic [7:0]  OFS_TRSEL  = 8'h1C;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTRL_CPL_LSB  = 4;
    localparam int SEL_TI_BIT    = 2;
    localparam int GATE_DPL_LSB  = 16;
    localparam int GATE_P_BIT    = 18;
    localparam int ST_PERMIT_BIT = 0;
    localparam int ST_GP_BIT     = 1;
    localparam int ST_NP_BIT     = 2;
    localparam int ST_TSF_BIT    = 3;
    localparam int ST_TSW_BIT    = 4;

    // ****************************************
    // descriptor codes and reset values
    // ****************************************
    localparam logic [3:0]  TYPE_TSS_IDLE  = 4'h9;
    localparam logic [3:0]  TYPE_TSS_BUSY  = 4'hB;
    localparam int          TYPE_BUSY_BIT  = 1;
    localparam logic [31:0] TSS_MIN_LIMIT  = 32'h0000_0067;
    localparam logic [15:0] RST_TR_SEL     = 16'h0000;
    localparam logic [31:0] RST_TR_BASE    = 32'h0000_0000;
    localparam logic [31:0] RST_TR_LIMIT   = 32'h0000_FFFF;
    localparam logic [8:0]  RST_TR_ATTR    = 9'h000;

    typedef enum logic [2:0] {
        OP_LTR, OP_SEGLOAD, OP_JMP, OP_CALL, OP_GATE_JMP, OP_GATE_CALL, OP_INT_GATE, OP_NONE
    } trd_op_t;

    typedef enum logic [1:0] { FLT_NONE, FLT_GP, FLT_NP, FLT_TS } trd_fault_t;

    // attr: [3:0] type, [4] code/data, [6:5] dpl, [7] present, [8] granularity
    typedef struct packed {
        logic [31:0] base;
        logic [19:0] limit;
        logic [8:0]  attr;
    } trd_desc_t;

    typedef struct packed {
        logic        is_tss;
        logic        busy;
        logic [1:0]  descriptor_privilege_level;
        logic        present;
        logic [31:0] eff_limit;
    } trd_dinfo_t;

endpackage

// >>> rtl/trd_desc_decode.sv
// decodes a segment descriptor into state-segment type, level and byte limit
module trd_desc_decode
    import trd_pkg::*;
(
    input  trd_pkg::trd_desc_t  desc,
    output trd_pkg::trd_dinfo_t info
);
    import trd_pkg::*;

    always_comb begin
        info.is_tss    = ~desc.attr[4] && (desc.attr[3:0] == TYPE_TSS_IDLE ||
                                          desc.attr[3:0] == TYPE_TSS_BUSY);
        info.busy      = desc.attr[3:0] == TYPE_TSS_BUSY;
        info.descriptor_privilege_level       = desc.attr[6:5];
        info.present   = desc.attr[7];
        // page granularity scales the raw limit to bytes
        info.eff_limit = desc.attr[8] ? {desc.limit, 12'hFFF} : {12'h000, desc.limit};
    end

endmodule

// >>> rtl/trd_priv_check.sv
// privilege comparison of current and requested level against a descriptor level
module trd_priv_check (
    input  wire logic [1:0] current_privilege_level,
    input  wire logic [1:0] requested_privilege_level,
    input  wire logic       use_rpl,
    input  wire logic [1:0] descriptor_privilege_level,
    output logic            ok
);

    assign ok = (current_privilege_level <= descriptor_privilege_level) && (!use_rpl || requested_privilege_level <= descriptor_privilege_level);

endmodule

// >>> rtl/trd_dispatch.sv
// task register and dispatch checks behind an apb register port
module trd_dispatch
    import trd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        iomap_req,
    input  wire logic [31:0] iomap_ofs,
    output logic             iomap_fault,
    output logic             dispatch_permit,
    output logic             general_protection_fault,
    output logic             not_present_fault,
    output logic             invalid_state_segment_fault,
    output logic             busy_set,
    output logic [15:0]      busy_sel,
    output logic             task_switched_flag,
    output logic [31:0]      tr_base,
    output logic [31:0]      tr_limit
);
    import trd_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [15:0] sel;
        trd_desc_t   desc;
        logic [31:0] gate;
        logic [15:0] tr_sel;
        logic [31:0] tr_base;
        logic [31:0] tr_limit;
        logic [8:0]  tr_attr;
        logic        tsw;
        logic        permit;
        trd_fault_t  fault;
        logic        busy_set;
        logic [15:0] busy_sel;
        logic        iofault;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } trd_state_t;

    trd_state_t  st_reg;
    trd_state_t  st_next;
    trd_dinfo_t  info;
    trd_op_t     op;
    logic [1:0]  current_privilege_level;
    logic        is_gate;
    logic        is_switch;
    logic [15:0] tgt_sel;
    logic [1:0]  chk_dpl;
    logic        priv_ok;
    logic        wr;
    logic        setup;
    logic        go;
    trd_fault_t  flt;
    // one flop per fault kind so each fault output comes straight from a register
    logic [2:0]  fault_pulse;

    function automatic logic ti_set(input logic [15:0] s);
        return s[SEL_TI_BIT];
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a[1:0] == 2'b00 && a <= OFS_TRSEL;
    endfunction

    trd_desc_decode u_dec (
        .desc (st_reg.desc),
        .info (info)
    );

    trd_priv_check u_prv (
        .current_privilege_level     (current_privilege_level),
        .requested_privilege_level     (st_reg.sel[1:0]),
        .use_rpl (is_gate),
        .descriptor_privilege_level     (chk_dpl),
        .ok      (priv_ok)
    );

    // ****************************************
    // request decode
    // ****************************************
    assign setup     = psel && !penable;
    assign wr        = psel && penable && pwrite && st_reg.pready && mapped(paddr);
    assign go        = wr && paddr == OFS_CTRL;
    assign op        = trd_op_t'(pwdata[2:0]);
    assign current_privilege_level       = pwdata[CTRL_CPL_LSB +: 2];
    assign is_gate   = op == OP_GATE_JMP || op == OP_GATE_CALL || op == OP_INT_GATE;
    assign is_switch = is_gate || op == OP_JMP || op == OP_CALL;
    // gate target with requested level dropped
    assign tgt_sel   = is_gate ? {st_reg.gate[15:2], 2'b00} : st_reg.sel;
    assign chk_dpl   = is_gate ? st_reg.gate[GATE_DPL_LSB +: 2] : info.descriptor_privilege_level;

    // ****************************************
    // check sequence, first failure wins
    // ****************************************
    always_comb begin
        flt = FLT_NONE;
        case (op)
            OP_LTR: begin
                if (current_privilege_level != 2'b00) begin
                    flt = FLT_GP;
                end else if (ti_set(tgt_sel) || !info.is_tss) begin
                    flt = FLT_GP;
                end else if (!info.present) begin
                    flt = FLT_NP;
                end else if (info.busy) begin
                    flt = FLT_GP;
                end
            end
            OP_SEGLOAD: begin
                // no state segment in data registers
                if (info.is_tss) begin
                    flt = FLT_GP;
                end
            end
            OP_JMP, OP_CALL, OP_GATE_JMP, OP_GATE_CALL, OP_INT_GATE: begin
                if (op != OP_INT_GATE && !priv_ok) begin
                    flt = FLT_GP;
                // gate in any table, must be present
                end else if (is_gate && !st_reg.gate[GATE_P_BIT]) begin
                    flt = FLT_NP;
                end else if (ti_set(tgt_sel) || !info.is_tss) begin
                    flt = FLT_GP;
                end else if (!info.present) begin
                    flt = FLT_NP;
                end else if (info.busy) begin
                    flt = FLT_GP;
                end else if (info.eff_limit < TSS_MIN_LIMIT) begin
                    flt = FLT_TS;
                end
            end
            default: begin
                flt = FLT_NONE;
            end
        endcase
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_next          = st_reg;
        st_next.permit   = 1'b0;
        st_next.busy_set = 1'b0;
        st_next.pready   = 1'b1;
        // map access is the only larger limit check
        st_next.iofault  = iomap_req && iomap_ofs > st_reg.tr_limit;
        if (wr) begin
            case (paddr)
                OFS_SEL:   st_next.sel        = pwdata[15:0];
                OFS_BASE:  st_next.desc.base  = pwdata;
                OFS_LIMIT: st_next.desc.limit = pwdata[19:0];
                OFS_ATTR:  st_next.desc.attr  = pwdata[8:0];
                OFS_GATE:  st_next.gate       = {13'h0, pwdata[18:0]};
                OFS_STATUS: begin
                    if (pwdata[ST_TSW_BIT]) begin
                        st_next.tsw = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (go && op != OP_NONE) begin
            st_next.fault = flt;
            if (flt == FLT_NONE) begin
                st_next.permit = 1'b1;
                if (op == OP_LTR || is_switch) begin
                    st_next.tr_sel   = tgt_sel;
                    st_next.tr_base  = st_reg.desc.base;
                    st_next.tr_limit = info.eff_limit;
                    st_next.tr_attr  = st_reg.desc.attr;
                    st_next.tr_attr[TYPE_BUSY_BIT] = 1'b1;
                    st_next.busy_set = 1'b1;
                    st_next.busy_sel = tgt_sel;
                end
                if (is_switch) begin
                    st_next.tsw = 1'b1;
                end
            end
        end
        if (setup) begin
            st_next.pslverr = !mapped(paddr);
            case (paddr)
                OFS_SEL:    st_next.prdata = {16'h0000, st_reg.sel};
                OFS_GATE:   st_next.prdata = st_reg.gate;
                OFS_STATUS: st_next.prdata = {27'h0000000, st_reg.tsw,
                                              st_reg.fault == FLT_TS,
                                              st_reg.fault == FLT_NP,
                                              st_reg.fault == FLT_GP,
                                              st_reg.fault == FLT_NONE};
                // store op sees the selector only
                OFS_TRSEL:  st_next.prdata = {16'h0000, st_reg.tr_sel};
                // hidden part and descriptor words are write only
                default:    st_next.prdata = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg          <= '0;
            // reset image of the task register
            st_reg.tr_sel   <= RST_TR_SEL;
            st_reg.tr_base  <= RST_TR_BASE;
            st_reg.tr_limit <= RST_TR_LIMIT;
            st_reg.tr_attr  <= RST_TR_ATTR;
            st_reg.fault    <= FLT_NONE;
        end else begin
            st_reg <= st_next;
        end
    end

    // visible selector plus cached base and limit
    assign prdata                      = st_reg.prdata;
    assign pready                      = st_reg.pready;
    assign pslverr                     = st_reg.pslverr;
    assign iomap_fault                 = st_reg.iofault;
    assign dispatch_permit             = st_reg.permit;
    assign general_protection_fault    = fault_pulse[0];
    assign not_present_fault           = fault_pulse[1];
    assign invalid_state_segment_fault = fault_pulse[2];
    assign busy_set                    = st_reg.busy_set;
    assign busy_sel                    = st_reg.busy_sel;
    assign task_switched_flag          = st_reg.tsw;
    assign tr_base                     = st_reg.tr_base;
    assign tr_limit                    = st_reg.tr_limit;

    // fault outputs pulse once per request; the status bits keep the outcome
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_pulse <= 3'h0;
        end else if (go && op != OP_NONE) begin
            fault_pulse <= {flt == FLT_TS, flt == FLT_NP, flt == FLT_GP};
        end else begin
            fault_pulse <= 3'h0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    AST_LOCAL_TABLE_GP: assert property (
        @(posedge pclk) disable iff (!presetn)
        go && op == OP_LTR && current_privilege_level == 2'b00 && ti_set(st_reg.sel) |=> general_protection_fault)
        else $error("local-table state segment reference not refused");

    AST_SEGLOAD_GP: assert property (
        @(posedge pclk) disable iff (!presetn)
        go && op == OP_SEGLOAD && info.is_tss |=> general_protection_fault && !dispatch_permit)
        else $error("state segment loaded into a segment register");

    AST_BUSY_REFUSED: assert property (
        @(posedge pclk) disable iff (!presetn)
        go && op == OP_CALL && priv_ok && !ti_set(tgt_sel) && info.is_tss
        && info.present && info.busy |=> general_protection_fault && !busy_set)
        else $error("busy task entered again");

    AST_SHORT_LIMIT_TS: assert property (
        @(posedge pclk) disable iff (!presetn)
        go && is_switch && flt == FLT_TS |=> invalid_state_segment_fault
        && task_switched_flag == $past(task_switched_flag))
        else $error("short state segment not refused");

    AST_LTR_PRIV: assert property (
        @(posedge pclk) disable iff (!presetn)
        go && op == OP_LTR && current_privilege_level != 2'b00 |=> general_protection_fault && $stable(tr_base))
        else $error("load op accepted above level 0");

    AST_COMMIT: assert property (
        @(posedge pclk) disable iff (!presetn)
        go && is_switch && flt == FLT_NONE |=> busy_set && task_switched_flag
        && dispatch_permit && busy_sel == $past(tgt_sel))
        else $error("committed switch did not load register and flags");

    AST_FAULT_KEEPS: assert property (
        @(posedge pclk) disable iff (!presetn)
        go && flt != FLT_NONE |=> !busy_set && $stable(tr_limit) && $stable(tr_base))
        else $error("faulting request changed the task register");

    AST_IOMAP: assert property (
        @(posedge pclk) disable iff (!presetn)
        iomap_req && iomap_ofs > tr_limit && !go |=> iomap_fault)
        else $error("map access beyond limit not flagged");

endmodule

// >>> test/trd_dispatch_test.sv
// self-checking bench for the task register dispatch checker
module trd_dispatch_test;
    timeunit 1ns;
    timeprecision 1ps;
    import trd_pkg::*;

    // ****************************************
    // signals
    // ****************************************
    localparam logic [3:0] R_OK = 4'h1;
    localparam logic [3:0] R_GP = 4'h2;
    localparam logic [3:0] R_NP = 4'h4;
    localparam logic [3:0] R_TS = 4'h8;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        iomap_req;
    logic [31:0] iomap_ofs;
    logic        iomap_fault;
    logic        dispatch_permit;
    logic        general_protection_fault;
    logic        not_present_fault;
    logic        invalid_state_segment_fault;
    logic        busy_set;
    logic [15:0] busy_sel;
    logic        task_switched_flag;
    logic [31:0] tr_base;
    logic [31:0] tr_limit;
    logic [31:0] rdat;
    logic        rerr;
    logic [15:0] bsel;
    int          failures;
    int          n_compared;
    int          cycles;

    trd_dispatch u_dut (
        .pclk                        (pclk),
        .presetn                     (presetn),
        .psel                        (psel),
        .penable                     (penable),
        .pwrite                      (pwrite),
        .paddr                       (paddr),
        .pwdata                      (pwdata),
        .prdata                      (prdata),
        .pready                      (pready),
        .pslverr                     (pslverr),
        .iomap_req                   (iomap_req),
        .iomap_ofs                   (iomap_ofs),
        .iomap_fault                 (iomap_fault),
        .dispatch_permit             (dispatch_permit),
        .general_protection_fault    (general_protection_fault),
        .not_present_fault           (not_present_fault),
        .invalid_state_segment_fault (invalid_state_segment_fault),
        .busy_set                    (busy_set),
        .busy_sel                    (busy_sel),
        .task_switched_flag          (task_switched_flag),
        .tr_base                     (tr_base),
        .tr_limit                    (tr_limit)
    );

    // ****************************************
    // clock, timeout and verdict
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // the whole sequence needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            complete_run;
        end
    end

    // ****************************************
    // compare and bus tasks
    // ****************************************
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_res(input logic [4:0] got, input logic [4:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t result=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr_en, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr_en;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        apb(1'b1, addr, wd);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check32(rdat, exp);
    endtask

    task automatic set_desc(input logic [31:0] b, input logic [31:0] l, input logic [3:0] t,
                            input logic [1:0] descriptor_privilege_level, input logic p, input logic s);
        wr(OFS_BASE, b);
        wr(OFS_LIMIT, l);
        wr(OFS_ATTR, {23'h0, 1'b0, p, descriptor_privilege_level, s, t});
    endtask

    task automatic set_gate(input logic [15:0] tgt, input logic [1:0] descriptor_privilege_level, input logic p);
        wr(OFS_GATE, {13'h0, p, descriptor_privilege_level, tgt});
    endtask

    // collects every pulse over three cycles so that a late or stray pulse shows
    task automatic dispatch(input trd_op_t op, input logic [1:0] current_privilege_level, input logic [3:0] exp);
        logic [4:0] got;
        got = 5'h00;
        wr(OFS_CTRL, 32'(op) | (32'(current_privilege_level) << CTRL_CPL_LSB));
        #1;
        repeat (3) begin
            got |= {busy_set, invalid_state_segment_fault, not_present_fault,
                    general_protection_fault, dispatch_permit};
            if (busy_set === 1'b1) begin
                bsel = busy_sel;
            end
            @(posedge pclk);
            #1;
        end
        check_res(got, {exp == R_OK && op != OP_SEGLOAD, exp});
    endtask

    task automatic io_chk(input logic [31:0] ofs, input logic exp);
        logic got;
        got = 1'b0;
        @(posedge pclk);
        iomap_req <= 1'b1;
        iomap_ofs <= ofs;
        @(posedge pclk);
        iomap_req <= 1'b0;
        repeat (2) begin
            #1;
            got |= iomap_fault;
            @(posedge pclk);
        end
        check32({31'h0, got}, {31'h0, exp});
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        iomap_req  = 1'b0;
        iomap_ofs  = 32'h0;
        presetn    = 1'b0;
        failures   = 0;
        n_compared = 0;
        cycles     = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        check32(tr_base, RST_TR_BASE);
        check32(tr_limit, RST_TR_LIMIT);
        rd_chk(OFS_TRSEL, {16'h0, RST_TR_SEL});
        set_desc(32'h1000_0000, TSS_MIN_LIMIT, TYPE_TSS_IDLE, 2'd0, 1'b1, 1'b0);
        rd_chk(OFS_BASE, 32'h0);
        rd_chk(OFS_LIMIT, 32'h0);
        rd_chk(OFS_ATTR, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check32(rdat, 32'h0);
        check32({31'h0, rerr}, 32'h1);
        // explicit load of the task register
        wr(OFS_SEL, 32'h0028);
        rd_chk(OFS_SEL, 32'h0028);
        dispatch(OP_LTR, 2'd1, R_GP);
        check32(tr_base, RST_TR_BASE);
        dispatch(OP_LTR, 2'd0, R_OK);
        check32({16'h0, bsel}, 32'h0028);
        rd_chk(OFS_TRSEL, 32'h0028);
        check32(tr_base, 32'h1000_0000);
        check32(tr_limit, TSS_MIN_LIMIT);
        rd_chk(OFS_STATUS, 32'h1 << ST_PERMIT_BIT);
        wr(OFS_SEL, 32'h002C);
        dispatch(OP_LTR, 2'd0, R_GP);
        // direct dispatch: privilege and limit boundary
        wr(OFS_SEL, 32'h0030);
        set_desc(32'h2000_0000, 32'h66, TYPE_TSS_IDLE, 2'd2, 1'b1, 1'b0);
        dispatch(OP_JMP, 2'd3, R_GP);
        dispatch(OP_JMP, 2'd2, R_TS);
        rd_chk(OFS_STATUS, 32'h1 << ST_TSF_BIT);
        check32(tr_base, 32'h1000_0000);
        wr(OFS_LIMIT, TSS_MIN_LIMIT);
        dispatch(OP_JMP, 2'd2, R_OK);
        check32({16'h0, bsel}, 32'h0030);
        check32(tr_base, 32'h2000_0000);
        rd_chk(OFS_TRSEL, 32'h0030);
        rd_chk(OFS_STATUS, 32'h11);
        io_chk(32'h67, 1'b0);
        io_chk(32'h68, 1'b1);
        // busy, type decode, presence and ordinary segment loads
        wr(OFS_SEL, 32'h0038);
        set_desc(32'h3000_0000, 32'h67, TYPE_TSS_BUSY, 2'd3, 1'b1, 1'b0);
        dispatch(OP_CALL, 2'd0, R_GP);
        set_desc(32'h3000_0000, 32'h67, 4'h1, 2'd3, 1'b1, 1'b0);
        dispatch(OP_JMP, 2'd0, R_GP);
        set_desc(32'h3000_0000, 32'h67, TYPE_TSS_IDLE, 2'd3, 1'b0, 1'b0);
        dispatch(OP_CALL, 2'd0, R_NP);
        rd_chk(OFS_TRSEL, 32'h0030);
        check32(tr_base, 32'h2000_0000);
        set_desc(32'h3000_0000, 32'hFFF, 4'h3, 2'd0, 1'b1, 1'b1);
        dispatch(OP_SEGLOAD, 2'd0, R_OK);
        set_desc(32'h3000_0000, 32'h67, TYPE_TSS_IDLE, 2'd0, 1'b1, 1'b0);
        dispatch(OP_SEGLOAD, 2'd0, R_GP);
        rd_chk(OFS_TRSEL, 32'h0030);
        wr(OFS_STATUS, 32'h1 << ST_TSW_BIT);
        rd_chk(OFS_STATUS, 32'h1 << ST_GP_BIT);
        // gated dispatch from a local-table gate
        // each task gets one descriptor; gates below target the one at 0x50, except gate 0x0057, whose target 0x54 is local
        set_desc(32'h4000_0000, 32'h67, TYPE_TSS_IDLE, 2'd0, 1'b1, 1'b0);
        set_gate(16'h0053, 2'd2, 1'b1);
        wr(OFS_SEL, 32'h0047);
        dispatch(OP_GATE_CALL, 2'd1, R_GP);
        wr(OFS_SEL, 32'h0046);
        dispatch(OP_GATE_JMP, 2'd3, R_GP);
        set_gate(16'h0057, 2'd2, 1'b1);
        dispatch(OP_GATE_JMP, 2'd2, R_GP);
        set_gate(16'h0053, 2'd2, 1'b1);
        dispatch(OP_GATE_JMP, 2'd2, R_OK);
        check32({16'h0, bsel}, 32'h0050);
        rd_chk(OFS_TRSEL, 32'h0050);
        check32(tr_base, 32'h4000_0000);
        rd_chk(OFS_STATUS, 32'h11);
        // interrupt vector through a gate ignores the gate level
        set_desc(32'h5000_0000, 32'h1234, TYPE_TSS_IDLE, 2'd0, 1'b1, 1'b0);
        set_gate(16'h0060, 2'd0, 1'b1);
        rd_chk(OFS_GATE, 32'h0004_0060);
        dispatch(OP_INT_GATE, 2'd3, R_OK);
        rd_chk(OFS_TRSEL, 32'h0060);
        check32(tr_limit, 32'h1234);
        complete_run;
    end
endmodule
